/* rtl/mcu_decode_consts.vh */
// Shared constants for the logic, move and branch decode block
`ifndef MCU_DECODE_CONSTS_VH
`define MCU_DECODE_CONSTS_VH

// Core clocks in one nominal machine cycle
`define MC_CLKS        4
`define MC_CNT_W       2
// Field widths
`define LEN_W          2
`define CYC_W          2
// Reset values
`define BYTE_RST       8'h00
`define ADDR_RST       16'h0000
`define LEN_RST        2'h0
`define CYC_RST        2'h0

`endif

/* rtl/mcu_logic_move_branch_decode.v */
// Decode and machine-cycle sequencing for logical, move, Boolean and branch instructions
`timescale 1ns/1ps
`include "mcu_decode_consts.vh"

module mcu_logic_move_branch_decode #(
    parameter MC_CLKS = `MC_CLKS
) (
    input  wire        clk,
    input  wire        clk_en,
    input  wire        arst_n,
    input  wire        start,
    input  wire [7:0]  opcode,
    input  wire [7:0]  operand1,
    input  wire [7:0]  operand2,
    input  wire [15:0] pc_next,
    input  wire [7:0]  acc_in,
    input  wire        carry_in,
    input  wire [15:0] data_pointer_in,
    input  wire [7:0]  src_byte,
    input  wire        bit_in,
    input  wire [15:0] ret_addr_in,
    input  wire [7:0]  mem_data_in,
    input  wire        wait_in,
    output wire        busy,
    output wire        ready,
    output reg         done_q,
    output reg         unsupported_q,
    output reg  [1:0]  len_q,
    output reg  [1:0]  cycles_q,
    output reg  [1:0]  mc_index_q,
    output reg  [7:0]  acc_q,
    output wire        acc_we,
    output reg         carry_q,
    output wire        carry_we,
    output reg  [7:0]  dest_q,
    output wire        dest_we,
    output reg         bit_q,
    output wire        bit_we,
    output reg  [15:0] data_pointer_q,
    output wire        data_pointer_we,
    output reg  [15:0] jump_addr_q,
    output wire        jump_we,
    output wire        push_byte,
    output wire        pop_byte,
    output reg  [15:0] ret_push_q,
    output wire        ret_push,
    output wire        ret_pop,
    output reg  [15:0] mem_addr_q,
    output wire        external_data_space_rd,
    output wire        external_data_space_wr,
    output wire        code_rd
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    localparam integer          MC_LAST_I = MC_CLKS - 1;
    localparam [`MC_CNT_W-1:0] MC_LAST   = MC_LAST_I[`MC_CNT_W-1:0];

    // Next instruction address plus signed offset
    function [15:0] rel_target;
        input [15:0] pc;
        input [7:0]  rel;
        begin
            rel_target = pc + {{8{rel[7]}}, rel};
        end
    endfunction

    reg                 state_q;
    reg [`MC_CNT_W-1:0] clk_cnt_q;
    reg                 acc_we_q, carry_we_q, dest_we_q, bit_we_q, data_pointer_we_q;
    reg                 jump_q, push_q, pop_q, rpush_q, rpop_q;
    reg                 xrd_q, xwr_q, crd_q, acc_mem_q;

    reg        sup, a_we, n_c, c_we, d_we, n_bit, b_we, p_we, jmp;
    reg        psh, pp, rpush, rpop, xr, xw, cr, amem;
    reg [1:0]  len, cyc;
    reg [7:0]  n_acc, n_dst, dec_val;
    reg [15:0] n_data_pointer, n_tgt, n_maddr;

    // One decode table gives length, machine cycles and every effect
    always @* begin
        sup     = 1'b1;
        len     = 2'h1;
        cyc     = 2'h1;
        n_acc   = acc_in;
        a_we    = 1'b0;
        n_c     = carry_in;
        c_we    = 1'b0;
        n_dst   = src_byte;
        d_we    = 1'b0;
        n_bit   = bit_in;
        b_we    = 1'b0;
        n_data_pointer  = data_pointer_in;
        p_we    = 1'b0;
        jmp     = 1'b0;
        n_tgt   = pc_next;
        psh     = 1'b0;
        pp      = 1'b0;
        rpush   = 1'b0;
        rpop    = 1'b0;
        n_maddr = `ADDR_RST;
        xr      = 1'b0;
        xw      = 1'b0;
        cr      = 1'b0;
        amem    = 1'b0;
        dec_val = src_byte - 8'h01;
        casez (opcode)
            8'b0110_011?: begin n_acc = acc_in ^ src_byte; a_we = 1'b1; end
            8'h64: begin len = 2'h2; n_acc = acc_in ^ operand1; a_we = 1'b1; end
            8'h62: begin len = 2'h2; n_dst = src_byte ^ acc_in; d_we = 1'b1; end
            8'h63: begin
                len = 2'h3; cyc = 2'h2; n_dst = src_byte ^ operand2; d_we = 1'b1;
            end
            8'he4: begin n_acc = `BYTE_RST; a_we = 1'b1; end
            8'hf4: begin n_acc = ~acc_in; a_we = 1'b1; end
            8'h23: begin n_acc = {acc_in[6:0], acc_in[7]}; a_we = 1'b1; end
            8'h33: begin
                n_acc = {acc_in[6:0], carry_in}; n_c = acc_in[7]; a_we = 1'b1; c_we = 1'b1;
            end
            8'h03: begin n_acc = {acc_in[0], acc_in[7:1]}; a_we = 1'b1; end
            8'h13: begin
                n_acc = {carry_in, acc_in[7:1]}; n_c = acc_in[0]; a_we = 1'b1; c_we = 1'b1;
            end
            8'b1110_1???, 8'b1110_011?: begin n_acc = src_byte; a_we = 1'b1; end
            8'he5: begin len = 2'h2; n_acc = src_byte; a_we = 1'b1; end
            8'h74: begin len = 2'h2; n_acc = operand1; a_we = 1'b1; end
            8'b1111_1???, 8'b1111_011?: begin n_dst = acc_in; d_we = 1'b1; end
            8'hf5: begin len = 2'h2; n_dst = acc_in; d_we = 1'b1; end
            8'b1010_1???, 8'b1000_1???, 8'b1000_011?: begin
                len = 2'h2; cyc = 2'h2; d_we = 1'b1;
            end
            8'b1010_011?: begin len = 2'h2; cyc = 2'h2; d_we = 1'b1; end
            8'b0111_1???, 8'b0111_011?: begin
                len = 2'h2; n_dst = operand1; d_we = 1'b1;
            end
            8'h85: begin len = 2'h3; cyc = 2'h2; d_we = 1'b1; end
            8'h75: begin len = 2'h3; cyc = 2'h2; n_dst = operand2; d_we = 1'b1; end
            8'h90: begin
                len = 2'h3; cyc = 2'h2; n_data_pointer = {operand1, operand2}; p_we = 1'b1;
            end
            8'h93: begin
                cyc = 2'h2; n_maddr = {8'h00, acc_in} + data_pointer_in; cr = 1'b1; amem = 1'b1;
            end
            8'h83: begin
                cyc = 2'h2; n_maddr = {8'h00, acc_in} + pc_next; cr = 1'b1; amem = 1'b1;
            end
            8'b1110_001?: begin
                cyc = 2'h2; n_maddr = {8'h00, src_byte}; xr = 1'b1; amem = 1'b1;
            end
            8'b1111_001?: begin
                cyc = 2'h2; n_maddr = {8'h00, src_byte}; n_dst = acc_in; xw = 1'b1;
            end
            8'he0: begin cyc = 2'h2; n_maddr = data_pointer_in; xr = 1'b1; amem = 1'b1; end
            8'hf0: begin
                cyc = 2'h2; n_maddr = data_pointer_in; n_dst = acc_in; xw = 1'b1;
            end
            8'hc0: begin len = 2'h2; cyc = 2'h2; psh = 1'b1; end
            8'hd0: begin len = 2'h2; cyc = 2'h2; pp = 1'b1; d_we = 1'b1; end
            8'b1100_1???, 8'b1100_011?: begin
                n_acc = src_byte; n_dst = acc_in; a_we = 1'b1; d_we = 1'b1;
            end
            8'hc5: begin
                len = 2'h2; n_acc = src_byte; n_dst = acc_in; a_we = 1'b1; d_we = 1'b1;
            end
            8'b1101_011?: begin
                n_acc = {acc_in[7:4], src_byte[3:0]};
                n_dst = {src_byte[7:4], acc_in[3:0]};
                a_we = 1'b1;
                d_we = 1'b1;
            end
            8'hc3: begin n_c = 1'b0; c_we = 1'b1; end
            8'hd3: begin n_c = 1'b1; c_we = 1'b1; end
            8'hb3: begin n_c = ~carry_in; c_we = 1'b1; end
            8'hc2: begin len = 2'h2; n_bit = 1'b0; b_we = 1'b1; end
            8'hd2: begin len = 2'h2; n_bit = 1'b1; b_we = 1'b1; end
            8'hb2: begin len = 2'h2; n_bit = ~bit_in; b_we = 1'b1; end
            8'h82: begin len = 2'h2; cyc = 2'h2; n_c = carry_in & bit_in; c_we = 1'b1; end
            8'hb0: begin len = 2'h2; cyc = 2'h2; n_c = carry_in & ~bit_in; c_we = 1'b1; end
            8'h72: begin len = 2'h2; cyc = 2'h2; n_c = carry_in | bit_in; c_we = 1'b1; end
            8'ha0: begin len = 2'h2; cyc = 2'h2; n_c = carry_in | ~bit_in; c_we = 1'b1; end
            8'ha2: begin len = 2'h2; n_c = bit_in; c_we = 1'b1; end
            8'h92: begin len = 2'h2; cyc = 2'h2; n_bit = carry_in; b_we = 1'b1; end
            8'h40, 8'h50: begin
                len = 2'h2; cyc = 2'h2; jmp = carry_in ^ opcode[4];
                n_tgt = rel_target(pc_next, operand1);
            end
            8'h20, 8'h30, 8'h10: begin
                len = 2'h3; cyc = 2'h2; jmp = bit_in ^ (opcode == 8'h30);
                n_tgt = rel_target(pc_next, operand2);
                n_bit = 1'b0;
                b_we = (opcode == 8'h10) & bit_in;
            end
            8'b????_0001: begin
                len = 2'h2; cyc = 2'h2; jmp = 1'b1; rpush = opcode[4];
                n_tgt = {pc_next[15:11], opcode[7:5], operand1};
            end
            8'h12, 8'h02: begin
                len = 2'h3; cyc = 2'h2; jmp = 1'b1; rpush = opcode[4];
                n_tgt = {operand1, operand2};
            end
            8'h22, 8'h32: begin
                cyc = 2'h2; jmp = 1'b1; rpop = 1'b1; n_tgt = ret_addr_in;
            end
            8'h80: begin
                len = 2'h2; cyc = 2'h2; jmp = 1'b1; n_tgt = rel_target(pc_next, operand1);
            end
            8'h73: begin cyc = 2'h2; jmp = 1'b1; n_tgt = {8'h00, acc_in} + data_pointer_in; end
            8'h60, 8'h70: begin
                len = 2'h2; cyc = 2'h2; jmp = (acc_in == 8'h00) ^ opcode[4];
                n_tgt = rel_target(pc_next, operand1);
            end
            8'hb5, 8'hb4: begin
                len = 2'h3; cyc = 2'h2; c_we = 1'b1;
                n_tgt = rel_target(pc_next, operand2);
                jmp = acc_in != (opcode[0] ? src_byte : operand1);
                n_c = acc_in < (opcode[0] ? src_byte : operand1);
            end
            8'b1011_1???, 8'b1011_011?: begin
                len = 2'h3; cyc = 2'h2; jmp = src_byte != operand1;
                n_c = src_byte < operand1; c_we = 1'b1;
                n_tgt = rel_target(pc_next, operand2);
            end
            8'b1101_1???: begin
                len = 2'h2; cyc = 2'h2; n_dst = dec_val; d_we = 1'b1;
                jmp = dec_val != 8'h00; n_tgt = rel_target(pc_next, operand1);
            end
            8'hd5: begin
                len = 2'h3; cyc = 2'h2; n_dst = dec_val; d_we = 1'b1;
                jmp = dec_val != 8'h00; n_tgt = rel_target(pc_next, operand2);
            end
            default: begin
                // Opcodes owned by other decode blocks complete as one-cycle no-ops here
                sup = 1'b0;
            end
        endcase
    end

    wire take = (state_q == ST_IDLE) & start;
    wire mc_end = (state_q == ST_RUN) & ~wait_in & (clk_cnt_q == MC_LAST);
    wire last_mc = mc_end & (mc_index_q == cycles_q - 2'h1);

    assign busy      = state_q == ST_RUN;
    assign ready     = state_q == ST_IDLE;
    assign {acc_we, carry_we, dest_we, bit_we, data_pointer_we} =
        {5{done_q}} & {acc_we_q, carry_we_q, dest_we_q, bit_we_q, data_pointer_we_q};
    assign {jump_we, push_byte, pop_byte, ret_push, ret_pop} =
        {5{done_q}} & {jump_q, push_q, pop_q, rpush_q, rpop_q};
    // Memory strobes stand for the whole second machine cycle so slow memory can insert waits
    assign external_data_space_rd  = busy & (mc_index_q == 2'h1) & xrd_q;
    assign external_data_space_wr  = busy & (mc_index_q == 2'h1) & xwr_q;
    assign code_rd   = busy & (mc_index_q == 2'h1) & crd_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q       <= ST_IDLE;
            clk_cnt_q     <= {`MC_CNT_W{1'b0}};
            mc_index_q    <= `CYC_RST;
            done_q        <= 1'b0;
            unsupported_q <= 1'b0;
            len_q         <= `LEN_RST;
            cycles_q      <= `CYC_RST;
            acc_q         <= `BYTE_RST;
            carry_q       <= 1'b0;
            dest_q        <= `BYTE_RST;
            bit_q         <= 1'b0;
            data_pointer_q        <= `ADDR_RST;
            jump_addr_q   <= `ADDR_RST;
            ret_push_q    <= `ADDR_RST;
            mem_addr_q    <= `ADDR_RST;
            acc_we_q      <= 1'b0;
            carry_we_q    <= 1'b0;
            dest_we_q     <= 1'b0;
            bit_we_q      <= 1'b0;
            data_pointer_we_q     <= 1'b0;
            jump_q        <= 1'b0;
            push_q        <= 1'b0;
            pop_q         <= 1'b0;
            rpush_q       <= 1'b0;
            rpop_q        <= 1'b0;
            xrd_q         <= 1'b0;
            xwr_q         <= 1'b0;
            crd_q         <= 1'b0;
            acc_mem_q     <= 1'b0;
        end else if (clk_en) begin
            done_q <= last_mc;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q       <= ST_RUN;
                        clk_cnt_q     <= {`MC_CNT_W{1'b0}};
                        mc_index_q    <= `CYC_RST;
                        unsupported_q <= ~sup;
                        len_q         <= len;
                        cycles_q      <= cyc;
                        acc_q         <= n_acc;
                        carry_q       <= n_c;
                        dest_q        <= n_dst;
                        bit_q         <= n_bit;
                        data_pointer_q        <= n_data_pointer;
                        jump_addr_q   <= n_tgt;
                        ret_push_q    <= pc_next;
                        mem_addr_q    <= n_maddr;
                        acc_we_q      <= a_we | amem;
                        carry_we_q    <= c_we;
                        dest_we_q     <= d_we;
                        bit_we_q      <= b_we;
                        data_pointer_we_q     <= p_we;
                        jump_q        <= jmp;
                        push_q        <= psh;
                        pop_q         <= pp;
                        rpush_q       <= rpush;
                        rpop_q        <= rpop;
                        xrd_q         <= xr;
                        xwr_q         <= xw;
                        crd_q         <= cr;
                        acc_mem_q     <= amem;
                    end
                end
                ST_RUN: begin
                    if (!wait_in) begin
                        clk_cnt_q <= (clk_cnt_q == MC_LAST) ? {`MC_CNT_W{1'b0}}
                                                            : clk_cnt_q + 1'b1;
                    end
                    if (last_mc) begin
                        state_q <= ST_IDLE;
                        if (acc_mem_q) begin
                            acc_q <= mem_data_in;
                        end
                    end else if (mc_end) begin
                        mc_index_q <= mc_index_q + 2'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // mcu_logic_move_branch_decode

/* verif/mcu_decode_asserts.sv */
// Port-level timing and strobe checks for the decode block
`timescale 1ns/1ps
module mcu_decode_asserts #(
    parameter MC_CLKS = 4
) (
    input wire       clk,
    input wire       arst_n,
    input wire       clk_en,
    input wire       start,
    input wire       wait_in,
    input wire       busy,
    input wire       ready,
    input wire       done_q,
    input wire       unsupported_q,
    input wire [1:0] len_q,
    input wire [1:0] cycles_q,
    input wire [1:0] mc_index_q,
    input wire       acc_we,
    input wire       dest_we,
    input wire       jump_we,
    input wire       external_data_space_rd,
    input wire       code_rd
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    reg [7:0] cnt_q;
    // Counts only unstalled clocks so wait states do not skew the figure
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) cnt_q <= 8'h00;
        else if (start && ready && clk_en) cnt_q <= 8'h00;
        else if (busy && clk_en && !wait_in) cnt_q <= cnt_q + 8'h01;
    end
    chk_cycle_count: assert property (done_q && !unsupported_q |-> cnt_q == cycles_q * MC_CLKS)
        else $error("done not after cycles times machine clocks");
    chk_done_timing: assert property (start && ready && clk_en |=> !done_q[*4] ##[1:36] done_q)
        else $error("done too early or missing");
    chk_done_pulse: assert property (done_q |=> !done_q)
        else $error("done longer than one cycle");
    chk_len_range: assert property (done_q && !unsupported_q |-> len_q != 2'h0 && cycles_q inside {2'h1, 2'h2})
        else $error("length or cycle count out of range");
    chk_done_idle: assert property (done_q |-> ready && !busy)
        else $error("done while still busy");
    chk_we_done: assert property (acc_we || dest_we || jump_we |-> done_q && !unsupported_q)
        else $error("write strobe outside done");
    chk_rd_window: assert property ($rose(external_data_space_rd || code_rd) |-> mc_index_q == 2'h1 ##0 (external_data_space_rd || code_rd)[*4])
        else $error("read strobe not held through second machine cycle");
    chk_rd_single: assert property (!(external_data_space_rd && code_rd))
        else $error("code and external reads together");
    chk_rd_end: assert property ($fell(external_data_space_rd || code_rd) |-> done_q)
        else $error("read strobe ended without done");
endmodule // mcu_decode_asserts

/* verif/mem_partner.sv */
// Behavioural code and external data memory with optional wait states
`timescale 1ns/1ps
module mem_partner #(
    parameter [3:0] WAITS = 4'h2
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        slow,
    input  wire        rd,
    input  wire [15:0] addr,
    output wire [7:0]  rdata,
    output wire        wait_in
);
    reg       rd_q;
    reg [3:0] wcnt_q;
    reg [7:0] last_q;
    // Idle bus toggles every cycle so a sample one cycle late sees the inverted byte
    assign rdata   = rd ? (addr[7:0] ^ 8'h3c) : ~last_q;
    assign wait_in = (wcnt_q != 4'h0);
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q   <= 1'b0;
            wcnt_q <= 4'h0;
            last_q <= 8'h00;
        end else begin
            rd_q   <= rd;
            last_q <= rdata;
            if (rd && !rd_q && slow) wcnt_q <= WAITS;
            else if (wcnt_q != 4'h0) wcnt_q <= wcnt_q - 4'h1;
        end
    end
endmodule // mem_partner

/* verif/tb_mcu_logic_move_branch_decode.sv */
// Self-checking bench for the logic, move and branch decode block
`timescale 1ns/1ps
module tb_mcu_logic_move_branch_decode;
    localparam MC_CLKS = 4;
    reg        clk, arst_n, start, carry_in, bit_in, slow;
    reg [7:0]  opcode, operand1, operand2, acc_in, src_byte;
    reg [15:0] pc_next, data_pointer_in;
    wire [7:0] acc_q, dest_q, mem_data_in;
    wire [15:0] data_pointer_q, jump_addr_q, ret_push_q, mem_addr_q;
    wire [1:0] len_q, cycles_q;
    wire done_q, unsupported_q, carry_q, bit_q, acc_we, bit_we, jump_we, ret_push, ret_pop;
    wire data_pointer_we, code_rd, external_data_space_rd, wait_in;
    wire carry_we, dest_we, push_byte, pop_byte, external_data_space_wr;
    reg [7:0] wr_cnt = 8'h00;
    integer num_errors = 0;
    integer checks_done = 0;
    reg [15:0] tbl [0:60] = '{16'h6332, 16'h6611, 16'h6221,
        16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
        16'h8532, 16'ha822, 16'h8822, 16'h7821, 16'h7621, 16'ha622,
        16'h9032, 16'h9312, 16'h8312, 16'he212, 16'hf212, 16'he012, 16'hf012,
        16'hc022, 16'hd022, 16'hc811, 16'hc521, 16'hc611, 16'hd611,
        16'h8222, 16'hb022, 16'h7222, 16'ha022, 16'ha221, 16'h9222,
        16'h4022, 16'h5022, 16'h2032, 16'h3032, 16'h1032, 16'h7312,
        16'h6022, 16'h7022, 16'hb532, 16'hb432, 16'hb832, 16'hb632, 16'hd822, 16'hd532,
        16'h1122, 16'h1232, 16'h2212, 16'h3212, 16'h0122, 16'h0232, 16'h8022,
        16'hc311, 16'hd311, 16'hb311, 16'hc221, 16'hd221, 16'hb221};
    mcu_logic_move_branch_decode #(.MC_CLKS(MC_CLKS)) DUT (.clk(clk), .clk_en(1'b1),
        .arst_n(arst_n), .start(start), .opcode(opcode), .operand1(operand1),
        .operand2(operand2), .pc_next(pc_next), .acc_in(acc_in), .carry_in(carry_in),
        .data_pointer_in(data_pointer_in), .src_byte(src_byte), .bit_in(bit_in), .ret_addr_in(16'h1234),
        .mem_data_in(mem_data_in), .wait_in(wait_in), .busy(), .ready(), .done_q(done_q),
        .unsupported_q(unsupported_q), .len_q(len_q), .cycles_q(cycles_q), .mc_index_q(),
        .acc_q(acc_q), .acc_we(acc_we), .carry_q(carry_q), .carry_we(carry_we),
        .dest_q(dest_q), .dest_we(dest_we), .bit_q(bit_q), .bit_we(bit_we),
        .data_pointer_q(data_pointer_q), .data_pointer_we(data_pointer_we), .jump_addr_q(jump_addr_q), .jump_we(jump_we),
        .push_byte(push_byte), .pop_byte(pop_byte),
        .ret_push_q(ret_push_q), .ret_push(ret_push), .ret_pop(ret_pop),
        .mem_addr_q(mem_addr_q), .external_data_space_rd(external_data_space_rd), .external_data_space_wr(external_data_space_wr), .code_rd(code_rd));
    mem_partner u_mem (.clk(clk), .arst_n(arst_n), .slow(slow), .rd(code_rd | external_data_space_rd),
        .addr(mem_addr_q), .rdata(mem_data_in), .wait_in(wait_in));
    // The write strobe is gone by done, so its width is counted as it happens
    always @(posedge clk) begin
        if (external_data_space_wr) begin
            wr_cnt <= wr_cnt + 8'h01;
        end
    end
    task chk(input [39:0] got, input [39:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Issues one instruction and returns in its done cycle, so pulses are still visible
    task exec(input [7:0] op, o1, o2, acc, src, input integer lat);
        integer n;
        begin
            @(posedge clk);
            start <= 1'b1;
            opcode <= op;
            operand1 <= o1;
            operand2 <= o2;
            acc_in <= acc;
            src_byte <= src;
            @(posedge clk);
            start <= 1'b0;
            n = 0;
            while (done_q !== 1'b1 && n < 100) begin
                @(posedge clk);
                #1 n = n + 1;
            end
            chk(n, lat);
        end
    endtask
    task t_timing;
        integer i;
        begin
            for (i = 0; i < 61; i = i + 1) begin
                exec(tbl[i][15:8], 8'h30, 8'h00, 8'h01, 8'h01, tbl[i][3:0] * MC_CLKS);
                chk({len_q, cycles_q}, {tbl[i][5:4], tbl[i][1:0]});
            end
        end
    endtask
    task t_data;
        reg [7:0] wr_base;
        begin
            exec(8'hf4, 8'h00, 8'h00, 8'h5a, 8'h00, 4);
            chk({acc_we, acc_q}, 9'h1a5);
            exec(8'h33, 8'h00, 8'h00, 8'h81, 8'h00, 4);
            chk({carry_we, carry_q, acc_q}, 10'h302);
            exec(8'h66, 8'h00, 8'h00, 8'h0f, 8'h3c, 4);
            chk(acc_q, 8'h33);
            exec(8'h90, 8'hab, 8'hcd, 8'h00, 8'h00, 8);
            chk({data_pointer_we, data_pointer_q}, 17'h1abcd);
            exec(8'he2, 8'h00, 8'h00, 8'h00, 8'h77, 8);
            chk({mem_addr_q[7:0], acc_q}, 16'h774b);
            exec(8'h93, 8'h00, 8'h00, 8'h05, 8'h00, 8);
            chk({mem_addr_q, acc_q}, 24'h120539);
            exec(8'h73, 8'h00, 8'h00, 8'h10, 8'h00, 8);
            chk({jump_we, jump_addr_q}, 17'h11210);
            exec(8'hb4, 8'h22, 8'h10, 8'h22, 8'h00, 8);
            chk(jump_we, 1'b0);
            exec(8'hb4, 8'h22, 8'h10, 8'h23, 8'h00, 8);
            chk({jump_we, jump_addr_q}, 17'h14012);
            exec(8'hd8, 8'h05, 8'h00, 8'h00, 8'h01, 8);
            chk({jump_we, dest_q}, 9'h000);
            exec(8'ha1, 8'h00, 8'h00, 8'h00, 8'h00, 8);
            chk(jump_addr_q, 16'h4500);
            exec(8'h12, 8'h56, 8'h78, 8'h00, 8'h00, 8);
            chk({ret_push, ret_push_q, jump_addr_q}, 33'h140025678);
            exec(8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8);
            chk({ret_pop, jump_addr_q}, 17'h11234);
            exec(8'h10, 8'h20, 8'h04, 8'h00, 8'h00, 8);
            chk({bit_we, bit_q, jump_addr_q}, 18'h24006);
            exec(8'hc0, 8'h30, 8'h00, 8'h00, 8'h5a, 8);
            chk({push_byte, pop_byte, dest_we, dest_q}, 11'h45a);
            exec(8'hd0, 8'h30, 8'h00, 8'h00, 8'hc3, 8);
            chk({push_byte, pop_byte, dest_we, dest_q}, 11'h3c3);
            wr_base = wr_cnt;
            exec(8'hf0, 8'h00, 8'h00, 8'ha5, 8'h00, 8);
            chk({wr_cnt - wr_base, mem_addr_q, dest_q}, {8'h04, 24'h1200a5});
            @(posedge clk);
            carry_in <= 1'b1;
            pc_next <= 16'h1002;
            bit_in <= 1'b0;
            slow <= 1'b1;
            exec(8'h80, 8'hfe, 8'h00, 8'h00, 8'h00, 8);
            chk(jump_addr_q, 16'h1000);
            exec(8'h40, 8'h10, 8'h00, 8'h00, 8'h00, 8);
            chk({jump_we, jump_addr_q}, 17'h11012);
            exec(8'ha2, 8'h20, 8'h00, 8'h00, 8'h00, 4);
            chk(carry_q, 1'b0);
            exec(8'he0, 8'h00, 8'h00, 8'h00, 8'h00, 10);
            chk({mem_addr_q, acc_q}, 24'h12003c);
            exec(8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 4);
            chk({unsupported_q, acc_we, jump_we}, 3'h4);
        end
    endtask
    task final_report;
        begin
            if (num_errors == 0 && checks_done > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 6000);
        num_errors = num_errors + 1;
        final_report;
    end
    initial begin
        {arst_n, start, carry_in, slow, opcode, operand1, operand2, acc_in, src_byte} = 0;
        bit_in = 1'b1;
        pc_next = 16'h4002;
        data_pointer_in = 16'h1200;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_timing;
        t_data;
        final_report;
    end
endmodule // tb_mcu_logic_move_branch_decode
bind mcu_logic_move_branch_decode mcu_decode_asserts #(.MC_CLKS(MC_CLKS)) u_chk (.clk(clk),
    .arst_n(arst_n), .clk_en(clk_en), .start(start), .wait_in(wait_in), .busy(busy),
    .ready(ready), .done_q(done_q), .unsupported_q(unsupported_q), .len_q(len_q),
    .cycles_q(cycles_q), .mc_index_q(mc_index_q), .acc_we(acc_we), .dest_we(dest_we),
    .jump_we(jump_we), .external_data_space_rd(external_data_space_rd), .code_rd(code_rd));
